/* File: hw/retseq_pkg.sv */
// Constants for the return and table-call sequencer
package retseq_pkg;
	localparam int PC_W        = 13;
	localparam int SP_W        = 8;
	localparam int NIB_W       = 4;
	localparam int DATA_W      = 32;
	localparam logic [SP_W-1:0] SP_RESET  = 8'h00;
	localparam logic [SP_W-1:0] FRAME_ONE = 8'h04;
	localparam logic [SP_W-1:0] FRAME_TWO = 8'h06;
	localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;
	// Machine cycle counts
	localparam logic [2:0] CYC_RET     = 3'h3;
	localparam logic [2:0] CYC_TBL     = 3'h3;
	localparam logic [2:0] CYC_TCALL2  = 3'h4;
	// Bank select value required for port access through a table entry
	localparam logic [3:0] BANK_PORTS  = 4'hF;
	localparam logic [3:0] PCC_FAST    = 4'h3;
	// Register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_CMD    = 8'h04;
	localparam logic [7:0] A_STACK  = 8'h08;
	localparam logic [7:0] A_TABLE  = 8'h0C;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_PC     = 8'h14;
	localparam logic [7:0] A_SP     = 8'h18;
	// Command codes
	localparam logic [1:0] CMD_RET   = 2'h0;
	localparam logic [1:0] CMD_RETURN_WITH_SKIP  = 2'h1;
	localparam logic [1:0] CMD_TABLE = 2'h2;
	// Table entry kinds
	localparam logic [1:0] ENT_BRANCH = 2'h0;
	localparam logic [1:0] ENT_CALL   = 2'h1;
	localparam logic [1:0] ENT_OTHER  = 2'h2;
endpackage : retseq_pkg

/* File: hw/stack_ram.sv */
// Nibble-wide stack memory with one read and one write port
`timescale 1ns/1ns
module stack_ram #(
	parameter int AW = 8
) (
	input  wire logic          clk_i,   // Clock
	input  wire logic          we_i,    // Write enable
	input  wire logic [AW-1:0] waddr_i, // Write address
	input  wire logic [3:0]    wdata_i, // Write nibble
	input  wire logic [AW-1:0] raddr_i, // Read address
	output logic      [3:0]    rdata_o  // Read nibble, combinational
);
	logic [3:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem[raddr_i];
endmodule : stack_ram

/* File: hw/retseq.sv */
// Return, return-with-skip and table-referenced instruction sequencer
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// - Plain return, one byte, three cycles, PC low from SP+2, middle from SP+3, high from SP.
// - First mode return restores bank enables from SP+1, SP grows by 4.
// - Second mode return takes bank enables from SP+4, SP grows by 6.
// - Thirteen-bit PC restores bit 12 from SP+1 bit 0.
// - Return-with-skip restores like return, then always skips next instruction.
// - Table instruction, one byte, three cycles, branch loads PC from table.
// - Table branch target is first byte bits 4..0 (3..0 for a 12-bit PC) joined with second byte.
// - First mode table call pushes PC bits 11..0, SP drops by 4; enables and PC12 go to a one-deep shadow, not the stack.
// - Second mode table call takes four cycles, PC12 at SP-5, SP drops 6.
// - Other table entries execute the held two-byte instruction.
// - Six-nibble frames only in second mode, four-nibble only in first.
module retseq #(
	parameter int PCW = retseq_pkg::PC_W
) (
	input  wire logic        CLOCK_I,   // 125 MHz clock
	input  wire logic        RESETN_I,  // Async reset, active low
	input  wire logic        PSEL_I,    // APB select
	input  wire logic        PENABLE_I, // APB enable
	input  wire logic        PWRITE_I,  // APB direction
	input  wire logic [7:0]  PADDR_I,   // APB byte address
	input  wire logic [31:0] PWDATA_I,  // APB write data
	output logic      [31:0] PRDATA_O,  // APB read data
	output logic             PREADY_O,  // APB ready
	output logic             PSLVERR_O, // APB error on unmapped address
	output logic             BUSY_O,    // Sequence running
	output logic             EXEC_O,    // Pulse: execute held two-byte instruction
	output logic             SKIP_O     // Level: next instruction is skipped
);
	// Only the two program counter widths of the family are served
	if (PCW != 12 && PCW != 13) begin : g_bad_pcw
		$error("PCW must be 12 or 13");
	end

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_C1 = 3'b001, S_C2 = 3'b011, S_C3 = 3'b010, S_C4 = 3'b110
	} st_e;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	st_e         st_r, st_nxt;
	logic        mode2_r, mode2_nxt;
	logic        mbe_r, mbe_nxt, rbe_r, rbe_nxt;
	logic [3:0]  mbs_r, mbs_nxt, pcc_r, pcc_nxt;
	logic [12:0] pc_r, pc_nxt;
	logic [7:0]  sp_r, sp_nxt;
	logic [1:0]  op_r, op_nxt, kind_r, kind_nxt;
	logic [7:0]  tb0_r, tb0_nxt, tb1_r, tb1_nxt;
	logic [2:0]  cyc_r, cyc_nxt, last_r, last_nxt;
	logic        skip_r, skip_nxt, exec_r, exec_nxt, err_r, err_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        rdy_r, rdy_nxt, slv_r, slv_nxt;
	logic        swe;
	logic [7:0]  swa, sra;
	logic [3:0]  swd, srd;
	logic        cmd_go;
	logic        sw_we;
	logic [3:0]  pop1, pop4;
	logic [3:0]  shadow1_r, shadow1_nxt, shadow4_r, shadow4_nxt;
	logic        busy_r, busy_nxt;
	logic        call_done;
	logic        pc12;

	stack_ram #(.AW(retseq_pkg::SP_W)) u_ram (
		.clk_i  (CLOCK_I),
		.we_i   (swe),
		.waddr_i(swa),
		.wdata_i(swd),
		.raddr_i(sra),
		.rdata_o(srd)
	);

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == retseq_pkg::A_CTRL) || (a == retseq_pkg::A_CMD)
			|| (a == retseq_pkg::A_STACK) || (a == retseq_pkg::A_TABLE)
			|| (a == retseq_pkg::A_STATUS) || (a == retseq_pkg::A_PC)
			|| (a == retseq_pkg::A_SP);
	endfunction : mapped

	// ------------------------------------------------------------
	// APB decode; one wait state, answer on second access cycle
	// ------------------------------------------------------------
	wire acc = PSEL_I && PENABLE_I && !rdy_r;
	wire wr  = acc && PWRITE_I && mapped(PADDR_I);
	assign cmd_go = wr && (PADDR_I == retseq_pkg::A_CMD) && (st_r == S_IDLE);
	assign sw_we  = wr && (PADDR_I == retseq_pkg::A_STACK) && (st_r == S_IDLE);

	always_comb begin
		rdy_nxt = acc;
		slv_nxt = acc && !mapped(PADDR_I);
		rd_nxt  = 32'h0000_0000;
		if (acc && !PWRITE_I) begin
			unique case (PADDR_I)
				retseq_pkg::A_CTRL:   rd_nxt = {20'h0_0000, pcc_r, mbs_r, 1'b0, rbe_r, mbe_r, mode2_r};
				retseq_pkg::A_TABLE:  rd_nxt = {16'h0000, tb1_r, tb0_r};
				retseq_pkg::A_STATUS: rd_nxt = {27'h000_0000, err_r, exec_r, skip_r, st_r != S_IDLE, 1'b0};
				retseq_pkg::A_PC:     rd_nxt = {19'h0_0000, pc_r};
				retseq_pkg::A_SP:     rd_nxt = {24'h00_0000, sp_r};
				retseq_pkg::A_STACK:  rd_nxt = {28'h000_0000, srd};
				default:              rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;   mode2_nxt = mode2_r; mbe_nxt = mbe_r; rbe_nxt = rbe_r;
		mbs_nxt = mbs_r; pcc_nxt = pcc_r;     pc_nxt = pc_r;   sp_nxt = sp_r;
		op_nxt = op_r;   kind_nxt = kind_r;   tb0_nxt = tb0_r; tb1_nxt = tb1_r;
		cyc_nxt = cyc_r; last_nxt = last_r;   skip_nxt = skip_r;
		exec_nxt = 1'b0; err_nxt = err_r;
		swe = 1'b0; swa = sp_r; swd = 4'h0; sra = PADDR_I[7:0];
		pop1 = 4'h0; pop4 = 4'h0;
		if (sw_we) begin
			swe = 1'b1;
			swa = PWDATA_I[15:8];
			swd = PWDATA_I[3:0];
		end
		if (wr && st_r == S_IDLE) begin
			unique case (PADDR_I)
				retseq_pkg::A_CTRL: begin
					mode2_nxt = PWDATA_I[0];
					mbe_nxt   = PWDATA_I[1];
					rbe_nxt   = PWDATA_I[2];
					mbs_nxt   = PWDATA_I[7:4];
					pcc_nxt   = PWDATA_I[11:8];
				end
				retseq_pkg::A_TABLE: begin
					tb0_nxt  = PWDATA_I[7:0];
					tb1_nxt  = PWDATA_I[15:8];
					kind_nxt = PWDATA_I[17:16];
				end
				retseq_pkg::A_PC: pc_nxt = PWDATA_I[12:0];
				retseq_pkg::A_SP: sp_nxt = PWDATA_I[7:0];
				default: ;
			endcase
		end
		if (cmd_go) begin
			op_nxt   = PWDATA_I[1:0];
			skip_nxt = 1'b0;
			cyc_nxt  = 3'h1;
			st_nxt   = S_C1;
			err_nxt  = (PWDATA_I[1:0] == retseq_pkg::CMD_TABLE)
				&& (kind_r == retseq_pkg::ENT_OTHER) && (mbs_r != retseq_pkg::BANK_PORTS);
			if (PWDATA_I[1:0] == retseq_pkg::CMD_TABLE && kind_r == retseq_pkg::ENT_CALL && mode2_r)
				last_nxt = retseq_pkg::CYC_TCALL2;
			else if (PWDATA_I[1:0] == retseq_pkg::CMD_TABLE)
				last_nxt = retseq_pkg::CYC_TBL;
			else
				last_nxt = retseq_pkg::CYC_RET;
		end
		if (st_r != S_IDLE) begin
			cyc_nxt = cyc_r + 3'h1;
			unique case (st_r)
				S_C1: st_nxt = S_C2;
				S_C2: st_nxt = S_C3;
				S_C3: st_nxt = (last_r == retseq_pkg::CYC_TCALL2) ? S_C4 : S_IDLE;
				S_C4: st_nxt = S_IDLE;
				default: st_nxt = S_IDLE;
			endcase
			if (op_r != retseq_pkg::CMD_TABLE) begin
				// One nibble per cycle: low, middle, then high together with the flag nibbles
				unique case (st_r)
					S_C1: begin sra = sp_r + 8'h02; pc_nxt[3:0] = srd; end
					S_C2: begin sra = sp_r + 8'h03; pc_nxt[7:4] = srd; end
					default: begin
						sra = sp_r;
						pc_nxt[11:8] = srd;
						pop1 = shadow1_r;
						pop4 = shadow4_r;
						if (mode2_r) begin
							{mbe_nxt, rbe_nxt} = pop4[1:0];
							sp_nxt = sp_r + retseq_pkg::FRAME_TWO;
						end else begin
							{mbe_nxt, rbe_nxt} = pop1[3:2];
							sp_nxt = sp_r + retseq_pkg::FRAME_ONE;
						end
						if (PCW == 13) pc_nxt[12] = pop1[0];
						skip_nxt = (op_r == retseq_pkg::CMD_RETURN_WITH_SKIP);
						st_nxt = S_IDLE;
					end
				endcase
			end else if (kind_r == retseq_pkg::ENT_CALL) begin
				// Push one nibble per cycle, finish on the last one
				swe = 1'b1;
				unique case (st_r)
					S_C1: begin
						swa = mode2_r ? sp_r - 8'h06 : sp_r - 8'h04;
						swd = pc_r[11:8];
					end
					S_C2: begin
						swa = mode2_r ? sp_r - 8'h03 : sp_r - 8'h01;
						swd = pc_r[7:4];
					end
					S_C3: begin
						swa = mode2_r ? sp_r - 8'h04 : sp_r - 8'h02;
						swd = pc_r[3:0];
					end
					default: begin
						swa = sp_r - 8'h05;
						swd = {3'h0, pc12};
					end
				endcase
				if (st_nxt == S_IDLE) begin
					sp_nxt = mode2_r ? sp_r - retseq_pkg::FRAME_TWO : sp_r - retseq_pkg::FRAME_ONE;
					pc_nxt = (PCW == 13) ? {tb0_r[4:0], tb1_r} : {1'b0, tb0_r[3:0], tb1_r};
				end
			end else if (st_nxt == S_IDLE) begin
				if (kind_r == retseq_pkg::ENT_BRANCH)
					pc_nxt = (PCW == 13) ? {tb0_r[4:0], tb1_r} : {1'b0, tb0_r[3:0], tb1_r};
				else
					exec_nxt = 1'b1;
			end
		end
		busy_nxt = (st_nxt != S_IDLE);
	end

	// Second read port is not free, so flag nibbles come from a small shadow
	assign pc12      = (PCW == 13) ? pc_r[12] : 1'b0;
	assign call_done = (st_r != S_IDLE) && (op_r == retseq_pkg::CMD_TABLE)
		&& (kind_r == retseq_pkg::ENT_CALL) && (st_nxt == S_IDLE);

	// A call keeps its flag nibbles in the shadows; only the second mode PC12 nibble also goes to the stack; one nesting level deep
	always_comb begin
		shadow1_nxt = shadow1_r;
		shadow4_nxt = shadow4_r;
		if (sw_we && PWDATA_I[15:8] == sp_r + 8'h01) shadow1_nxt = PWDATA_I[3:0];
		if (sw_we && PWDATA_I[15:8] == sp_r + 8'h04) shadow4_nxt = PWDATA_I[3:0];
		if (call_done && mode2_r) begin
			shadow1_nxt = {3'h0, pc12};
			shadow4_nxt = {2'h0, mbe_r, rbe_r};
		end else if (call_done) begin
			shadow1_nxt = {mbe_r, rbe_r, 1'b0, pc12};
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_r <= S_IDLE; mode2_r <= 1'b0; mbe_r <= 1'b0; rbe_r <= 1'b0;
			mbs_r <= 4'h0; pcc_r <= 4'h0; pc_r <= retseq_pkg::PC_RESET;
			sp_r <= retseq_pkg::SP_RESET; op_r <= 2'h0; kind_r <= 2'h0;
			tb0_r <= 8'h00; tb1_r <= 8'h00; cyc_r <= 3'h0; last_r <= 3'h0;
			skip_r <= 1'b0; exec_r <= 1'b0; err_r <= 1'b0;
			rd_r <= 32'h0000_0000; rdy_r <= 1'b0; slv_r <= 1'b0;
			shadow1_r <= 4'h0; shadow4_r <= 4'h0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt; mode2_r <= mode2_nxt; mbe_r <= mbe_nxt; rbe_r <= rbe_nxt;
			mbs_r <= mbs_nxt; pcc_r <= pcc_nxt; pc_r <= pc_nxt;
			sp_r <= sp_nxt; op_r <= op_nxt; kind_r <= kind_nxt;
			tb0_r <= tb0_nxt; tb1_r <= tb1_nxt; cyc_r <= cyc_nxt; last_r <= last_nxt;
			skip_r <= skip_nxt; exec_r <= exec_nxt; err_r <= err_nxt;
			rd_r <= rd_nxt; rdy_r <= rdy_nxt; slv_r <= slv_nxt;
			shadow1_r <= shadow1_nxt; shadow4_r <= shadow4_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Skip is only an indication; the fetch unit advances PC past it
	assign SKIP_O    = skip_r;
	assign EXEC_O    = exec_r;
	assign BUSY_O    = busy_r;
	assign PRDATA_O  = rd_r;
	assign PREADY_O  = rdy_r;
	assign PSLVERR_O = slv_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_ret_len;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(cmd_go && PWDATA_I[1:0] == retseq_pkg::CMD_RET) |-> ##4 (st_r == S_IDLE);
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("return not three cycles");
	property p_sp1;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(st_r == S_C3 && op_r != retseq_pkg::CMD_TABLE && !mode2_r)
			|=> (sp_r == $past(sp_r) + retseq_pkg::FRAME_ONE);
	endproperty
	a_sp1: assert property (p_sp1) else $error("first mode pop size wrong");
	property p_sp2;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(st_r == S_C3 && op_r != retseq_pkg::CMD_TABLE && mode2_r)
			|=> (sp_r == $past(sp_r) + retseq_pkg::FRAME_TWO);
	endproperty
	a_sp2: assert property (p_sp2) else $error("second mode pop size wrong");
	property p_skip;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(cmd_go && PWDATA_I[1:0] == retseq_pkg::CMD_RETURN_WITH_SKIP) |-> ##4 skip_r;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not set");
	property p_tcall2;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(cmd_go && PWDATA_I[1:0] == retseq_pkg::CMD_TABLE && kind_r == retseq_pkg::ENT_CALL
			&& mode2_r) |-> ##4 (st_r == S_C4) ##1 (st_r == S_IDLE);
	endproperty
	a_tcall2: assert property (p_tcall2) else $error("second mode call not four cycles");
	property p_exec;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		exec_r |-> ($past(kind_r) == retseq_pkg::ENT_OTHER && st_r == S_IDLE);
	endproperty
	a_exec: assert property (p_exec) else $error("exec without other entry");
	property p_call_sp1;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(call_done && !mode2_r) |=> (sp_r == $past(sp_r) - retseq_pkg::FRAME_ONE);
	endproperty
	a_call_sp1: assert property (p_call_sp1) else $error("first mode push size wrong");
	property p_cyc;
		@(posedge CLOCK_I) disable iff (!RESETN_I)
		(st_r != S_IDLE) |-> (cyc_r <= last_r);
	endproperty
	a_cyc: assert property (p_cyc) else $error("sequence ran past its cycle count");
	c_return_with_skip: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) $rose(skip_r));
	c_exec: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) exec_r);
	c_c4:   cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) st_r == S_C4);
endmodule : retseq

/* File: verif/table_rom.sv */
// Program memory table image seen by the table instruction
`timescale 1ns/1ns
module table_rom (
	input  wire logic [3:0]  idx_i,   // Table slot
	output logic      [17:0] entry_o  // Kind, second byte, first byte
);
	// First byte carries junk in bits 7..5 so the target slice is exercised
	always_comb begin
		entry_o[7:0]   = {3'h0, idx_i[0], idx_i} ^ 8'hA5;
		entry_o[15:8]  = {idx_i, ~idx_i};
		entry_o[17:16] = (idx_i[1:0] == 2'h3) ? 2'h2 : {1'b0, idx_i[0]};
	end
endmodule : table_rom

/* File: verif/retseq_tb.sv */
// Self-checking bench for the return and table sequencer
`timescale 1ns/1ns
module retseq_tb;
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel  = 1'b0;
	logic        pen   = 1'b0;
	logic        pwr   = 1'b0;
	logic [7:0]  padr  = 8'h00;
	logic [31:0] pwd   = 32'h0000_0000;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic        busy;
	logic        exe;
	logic        skp;
	logic [3:0]  idx   = 4'h0;
	logic [17:0] ent;
	logic [31:0] lf    = 32'h0000_156b;
	logic [31:0] rd;
	logic        er;
	int          n_errors = 0;
	int          n_tests  = 0;
	int          nb;
	int          ne;

	always #4 clk = ~clk;

	retseq #(.PCW(13)) retseq_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(prdy), .PSLVERR_O(perr), .BUSY_O(busy), .EXEC_O(exe), .SKIP_O(skp));
	table_rom table_rom_inst (.idx_i(idx), .entry_o(ent));

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		padr <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 50);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (k >= 50)
			chk("pready wait", 0, 1);
	endtask : apb

	task automatic run(input logic [1:0] c, input logic [2:0] cyc);
		int k;
		nb = 0;
		ne = 0;
		apb(1'b1, retseq_pkg::A_CMD, {30'h0, c});
		// First look is at the pready edge, where the first busy cycle stands
		for (k = 0; k < 12; k++) begin
			if (busy === 1'b1) nb++;
			if (exe === 1'b1) ne++;
			@(posedge clk);
		end
		chk("busy cycles", {29'h0, cyc}, nb);
	endtask : run

	initial begin
		#200000;
		chk("watchdog", 0, 1);
		close_out();
	end

	initial begin
		logic [3:0]  n [6];
		logic [7:0]  s;
		logic [12:0] p;
		logic [1:0]  f;
		logic [3:0]  c;
		int          i;
		int          k;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, retseq_pkg::A_SP, 32'h0);
		chk("sp reset", 0, rd);
		apb(1'b0, retseq_pkg::A_PC, 32'h0);
		chk("pc reset", 0, rd);
		// ----------------------------------------
		// Returns, both modes, plain and skipping
		// ----------------------------------------
		for (i = 0; i < 8; i++) begin
			apb(1'b0, retseq_pkg::A_SP, 32'h0);
			s = rd[7:0];
			for (k = 0; k < 6; k++) begin
				lf = lfsr(lf);
				n[k] = lf[3:0];
				apb(1'b1, retseq_pkg::A_STACK, {16'h0, s + 8'(k), 4'h0, n[k]});
			end
			lf = lfsr(lf);
			c = (lf[11:8] == retseq_pkg::PCC_FAST) ? 4'h0 : lf[11:8];
			apb(1'b1, retseq_pkg::A_CTRL, {20'h0, c, 4'hF, 3'h0, i[0]});
			run(i[1] ? retseq_pkg::CMD_RETURN_WITH_SKIP : retseq_pkg::CMD_RET, retseq_pkg::CYC_RET);
			apb(1'b0, retseq_pkg::A_PC, 32'h0);
			chk("ret pc", {19'h0, n[1][0], n[0], n[3], n[2]}, rd);
			apb(1'b0, retseq_pkg::A_SP, 32'h0);
			chk("ret sp", {24'h0, s + (i[0] ? 8'h06 : 8'h04)}, rd);
			f = i[0] ? {n[4][0], n[4][1]} : {n[1][2], n[1][3]};
			apb(1'b0, retseq_pkg::A_CTRL, 32'h0);
			chk("bank flags", {30'h0, f}, {30'h0, rd[2:1]});
			chk("clock field", {28'h0, c}, {28'h0, rd[11:8]});
			chk("skip", {31'h0, i[1]}, {31'h0, skp});
		end
		// ----------------------------------------
		// Table entries: branch, call, other
		// ----------------------------------------
		for (i = 0; i < 8; i++) begin
			idx = 4'(i);
			lf = lfsr(lf);
			f = lf[1:0];
			apb(1'b1, retseq_pkg::A_CTRL, {24'h0, (i == 7) ? 4'h5 : 4'hF, 1'b0, f, i[2]});
			apb(1'b0, retseq_pkg::A_SP, 32'h0);
			s = rd[7:0];
			apb(1'b0, retseq_pkg::A_PC, 32'h0);
			p = rd[12:0];
			apb(1'b1, retseq_pkg::A_TABLE, {14'h0, ent});
			run(retseq_pkg::CMD_TABLE, (ent[17:16] == retseq_pkg::ENT_CALL && i[2])
				? retseq_pkg::CYC_TCALL2 : retseq_pkg::CYC_TBL);
			apb(1'b0, retseq_pkg::A_SP, 32'h0);
			chk("table sp", {24'h0, s - ((ent[17:16] == retseq_pkg::ENT_CALL)
				? (i[2] ? 8'h06 : 8'h04) : 8'h00)}, rd);
			if (ent[17:16] != retseq_pkg::ENT_OTHER) begin
				apb(1'b0, retseq_pkg::A_PC, 32'h0);
				chk("table pc", {19'h0, ent[4:0], ent[15:8]}, rd);
			end else begin
				chk("exec pulses", 1, ne);
				apb(1'b0, retseq_pkg::A_STATUS, 32'h0);
				chk("bank select err", {31'h0, i == 7}, {31'h0, rd[4]});
			end
			// Flags inverted first so the return must really restore them
			if (ent[17:16] == retseq_pkg::ENT_CALL) begin
				apb(1'b1, retseq_pkg::A_CTRL, {24'h0, 4'hF, 1'b0, ~f, i[2]});
				run(retseq_pkg::CMD_RET, retseq_pkg::CYC_RET);
				apb(1'b0, retseq_pkg::A_PC, 32'h0);
				chk("call return pc", {19'h0, p}, rd);
				apb(1'b0, retseq_pkg::A_SP, 32'h0);
				chk("call return sp", {24'h0, s}, rd);
				apb(1'b0, retseq_pkg::A_CTRL, 32'h0);
				chk("call flags", {30'h0, f}, {30'h0, rd[2:1]});
			end
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 1, {31'h0, er});
		apb(1'b0, retseq_pkg::A_SP, 32'h0);
		chk("mapped err", 0, {31'h0, er});
		close_out();
	end
endmodule : retseq_tb
